// *** hdl/rhp_top.sv ***
// root hub per-port status and control registers behind a classic wishbone slave
//
// Contract
// - There is one port status register for each of the two downstream ports.
// - The first port's register is read at index 15 hex and the second's at index 16 hex.
// - The first port's register is written at index 95 hex and the second's at index 96 hex.
// - Port status sits in the low 16 bits and the matching change flags in the high 16 bits.
// - A status-changing write made while a transaction runs on that port waits until it ends.
// - Change flags sit at bits 16 to 20 for connect, enable, suspend, overcurrent and reset done.
// - Status sits at bits 0 to 4 for connected, enabled, suspended, overcurrent, reset, 8 power, 9 low speed.
// - The reset done flag sets when the 10 ms reset ends and is cleared by writing a one.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "rhp_cfg.svh"
module rhp_top #(
  parameter int unsigned RESET_CYCLES = `RHP_PORT_RESET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] port_connect_i,
  input wire logic [1:0] port_overcurrent_i,
  input wire logic [1:0] port_low_speed_i,
  input wire logic [1:0] port_busy_i,
  output logic [1:0] port_reset_drive_o,
  output logic [1:0] port_power_o
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  rhp_pkg::rhp_bus_st_t state;
  rhp_pkg::rhp_bus_st_t next_state;
  rhp_pkg::rhp_word_t status [`RHP_PORT_COUNT];
  rhp_pkg::rhp_word_t wmask;
  rhp_pkg::rhp_word_t next_rdata;
  logic [`RHP_IDX_W-1:0] idx;
  logic [1:0] pend;
  logic [1:0] wr_hit;
  logic [1:0] wr_pulse;
  logic req;
  logic stall;

  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[9:2];
  // reserved bits carry no action, so unselected lanes are simply zeroed
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // each port answers its read code and its write code for writes
  assign wr_hit[0] = wb_we_i && (idx == `RHP_RD_IDX_P1 || idx == `RHP_WR_IDX_P1);
  assign wr_hit[1] = wb_we_i && (idx == `RHP_RD_IDX_P2 || idx == `RHP_WR_IDX_P2);

  // a write is only accepted once the port has no parked write left
  assign stall = |(wr_hit & pend);

  // the write takes effect at the edge where the master samples ack
  assign wr_pulse = (req && wb_ack_o) ? wr_hit : 2'b00;

  // ----------------------------------------
  // read data mux; write codes and unmapped indices read zero
  // ----------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (!wb_we_i)
    begin
      if (idx == `RHP_RD_IDX_P1)
        next_rdata = status[0];
      else if (idx == `RHP_RD_IDX_P2)
        next_rdata = status[1];
    end
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      rhp_pkg::BUS_IDLE:
        if (req && !stall)
          next_state = rhp_pkg::BUS_ACK;
      rhp_pkg::BUS_ACK:
        next_state = rhp_pkg::BUS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= rhp_pkg::BUS_IDLE;
    else
      state <= next_state;
  end

  // read data captured when ack is raised, held for the ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (state == rhp_pkg::BUS_IDLE && req && !stall)
      wb_dat_o <= next_rdata;
  end

  assign wb_ack_o = (state == rhp_pkg::BUS_ACK);  // ack lasts exactly one cycle

  // ----------------------------------------
  // port instances
  // ----------------------------------------
  // separate strobes and state per port keep the ports independent
  for (genvar p = 0; p < `RHP_PORT_COUNT; p++)
  begin : g_port
    rhp_port #(.RESET_CYCLES(RESET_CYCLES)) u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_pulse[p]),
      .wdata_i(wb_dat_i & wmask),
      .busy_i(port_busy_i[p]),
      .connect_i(port_connect_i[p]),
      .overcur_i(port_overcurrent_i[p]),
      .low_speed_i(port_low_speed_i[p]),
      .status_o(status[p]),
      .pend_o(pend[p]),
      .reset_drive_o(port_reset_drive_o[p]),
      .power_o(port_power_o[p])
    );
  end

  // ----------------------------------------
  // length of the first port's reset signalling
  // ----------------------------------------
  logic [31:0] drive_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !port_reset_drive_o[0])
      drive_cnt <= 32'h0000_0000;
    else
      drive_cnt <= drive_cnt + 32'h0000_0001;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rd_p1;
    wb_ack_o && !wb_we_i && idx == `RHP_RD_IDX_P1;
  endsequence

  sequence s_wr_p1_idle;
    wb_ack_o && wb_we_i && idx == `RHP_WR_IDX_P1 && !port_busy_i[0];
  endsequence

  sequence s_wr_p1_busy;
    wb_ack_o && req && wr_hit[0] && port_busy_i[0];
  endsequence

  sequence s_wr_p2_idle;
    wb_ack_o && wb_we_i && idx == `RHP_WR_IDX_P2 && !port_busy_i[1];
  endsequence

  // an acknowledge is a single cycle and only answers a live request
  AST_ACK_PULSE: assert property (wb_ack_o |-> req ##1 !wb_ack_o)
    else $error("ack not a single cycle inside a request");

  // a request without a parked write is answered on the next cycle
  AST_ACK_LATENCY: assert property ((req && !wb_ack_o && !stall) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  // reading the first port's code returns its register of the cycle before
  AST_READ_P1: assert property (s_rd_p1 |-> wb_dat_o == $past(status[0]))
    else $error("port one read data mismatch");

  // reading the second port's code returns its register
  AST_READ_P2: assert property ((wb_ack_o && !wb_we_i && idx == `RHP_RD_IDX_P2) |-> wb_dat_o == $past(status[1]))
    else $error("port two read data mismatch");

  // reserved positions of the status word always read zero
  AST_RESERVED: assert property (wb_ack_o |-> (wb_dat_o[31:21] == 11'h000 && wb_dat_o[15:10] == 6'h00 && wb_dat_o[7:5] == 3'h0))
    else $error("reserved bits read as one");

  // power set through the write code shows one cycle later
  AST_WRITE_P1: assert property ((s_wr_p1_idle ##0 (wb_sel_i[1] && wb_dat_i[`RHP_B_POWER] && !wb_dat_i[`RHP_B_LOWSPEED])) |=> port_power_o[0])
    else $error("port one power set lost");

  // a write during a transaction is parked, not applied
  AST_DEFER_PARK: assert property (s_wr_p1_busy |=> pend[0] && $stable(port_power_o[0]))
    else $error("write not deferred while busy");

  // a parked write waits while busy and clears the cycle after the port goes idle
  AST_DEFER_APPLY: assert property ((pend[0] && !port_busy_i[0]) |=> !pend[0])
    else $error("parked write not applied when idle");

  // no new write is acknowledged to a port with a parked write
  AST_DEFER_STALL: assert property ((pend[0] && req && wr_hit[0] && !wb_ack_o) |=> !wb_ack_o)
    else $error("write accepted over a parked write");

  // the flag is registered, so it shows the cycle after reset signalling ends
  AST_RESET_DONE: assert property ($fell(port_reset_drive_o[0]) |=> status[0][`RHP_B_RST_CHG])
    else $error("reset done flag not set at end of reset");

  // writing one clears reset done when no reset end coincides (the done pulse follows the drive)
  AST_RESET_CLEAR: assert property ((wr_pulse[0] && !port_busy_i[0] && !pend[0] && wb_sel_i[2]
    && wb_dat_i[`RHP_B_RST_CHG] && !port_reset_drive_o[0] && !$past(port_reset_drive_o[0]))
    |=> !status[0][`RHP_B_RST_CHG])
    else $error("reset done flag not cleared by write one");

  // a write to port one leaves port two alone while its inputs and timer hold still
  AST_ISOLATE: assert property ((wr_pulse[0] && !wr_pulse[1] && !pend[1] && !port_reset_drive_o[1]
    && !$past(port_reset_drive_o[1]) && !(status[1][`RHP_B_SUSPENDED] && !status[1][`RHP_B_ENABLED])
    && $stable(port_connect_i[1]) && $stable(port_overcurrent_i[1]) && $stable(port_low_speed_i[1]))
    |=> $stable(status[1]))
    else $error("port two changed by a port one write");

  // low speed shows only on a connected port
  AST_LOWSPEED: assert property (status[0][`RHP_B_LOWSPEED] |-> status[0][`RHP_B_CONNECTED])
    else $error("low speed without connection");

  // no request, no acknowledge on the next cycle
  AST_ACK_IDLE: assert property (!req |=> !wb_ack_o)
    else $error("ack without a request");

  // reads never wait on a parked write
  AST_READ_NO_STALL: assert property ((req && !wb_we_i && !wb_ack_o) |=> wb_ack_o)
    else $error("read not answered on the next cycle");

  // any read index other than the two port codes returns zero
  AST_READ_UNMAPPED: assert property ((wb_ack_o && !wb_we_i
    && idx != `RHP_RD_IDX_P1 && idx != `RHP_RD_IDX_P2) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // a write cycle hands back zero read data
  AST_WRITE_READS_ZERO: assert property ((wb_ack_o && wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("write cycle returned data");

  // power set through the second port's write code
  AST_WRITE_P2: assert property ((s_wr_p2_idle ##0 (wb_sel_i[1] && wb_dat_i[`RHP_B_POWER])) |=> port_power_o[1])
    else $error("port two power set lost");

  // power cleared through the second port's write code
  AST_POWER_OFF_P2: assert property ((s_wr_p2_idle ##0 (wb_sel_i[1] && wb_dat_i[`RHP_B_LOWSPEED]
    && !wb_dat_i[`RHP_B_POWER])) |=> !port_power_o[1])
    else $error("port two power clear lost");

  // the first port's power only rises after a write to it was applied
  AST_POWER_SRC_P1: assert property ($rose(port_power_o[0]) |-> $past(wr_pulse[0] || pend[0]))
    else $error("port one power rose without a write");

  // the second port's power only rises after a write to that port
  AST_POWER_SRC_P2: assert property ($rose(port_power_o[1]) |-> $past(wr_pulse[1] || pend[1]))
    else $error("port two power rose without its own write");

  // reserved positions of both registers stay zero at all times
  AST_RESERVED_LIVE: assert property ((status[0] & 32'hffe0_fce0) == 32'h0000_0000
    && (status[1] & 32'hffe0_fce0) == 32'h0000_0000)
    else $error("reserved register bit set");

  // a change of the first port's connection raises its connect change flag
  AST_CONN_CHG: assert property ($changed(status[0][`RHP_B_CONNECTED]) |-> status[0][`RHP_B_CONN_CHG])
    else $error("connect change flag missing");

  // a change of the first port's overcurrent raises its overcurrent change flag
  AST_OC_CHG: assert property ($changed(status[0][`RHP_B_OVERCUR]) |-> status[0][`RHP_B_OC_CHG])
    else $error("overcurrent change flag missing");

  // an enabled port is always a connected port
  AST_EN_NEEDS_CONN: assert property (status[0][`RHP_B_ENABLED] |-> status[0][`RHP_B_CONNECTED])
    else $error("enabled without connection");

  // suspend goes away the cycle after the port loses its enable
  AST_SUSP_DROP: assert property ($fell(status[0][`RHP_B_ENABLED]) |=> !status[0][`RHP_B_SUSPENDED])
    else $error("suspend kept on a disabled port");

  // a reset command to a connected idle port starts reset signalling on the next cycle
  AST_RESET_START: assert property ((s_wr_p1_idle ##0 (wb_sel_i[0] && wb_dat_i[`RHP_B_RESET]
    && status[0][`RHP_B_CONNECTED] && !port_reset_drive_o[0])) |=> port_reset_drive_o[0])
    else $error("port reset not started");

  // low speed shows only on a connected second port
  AST_LOWSPEED_P2: assert property (status[1][`RHP_B_LOWSPEED] |-> status[1][`RHP_B_CONNECTED])
    else $error("port two low speed without connection");

  // the end of the second port's reset signalling raises its reset done flag
  AST_RESET_DONE_P2: assert property ($fell(port_reset_drive_o[1]) |=> status[1][`RHP_B_RST_CHG])
    else $error("port two reset done flag not set");

  // reset signalling lasts exactly the configured number of cycles
  AST_RESET_LEN: assert property ($fell(port_reset_drive_o[0]) |-> drive_cnt == RESET_CYCLES[31:0])
    else $error("port reset length wrong");

  // the reset done flag only goes away through an applied write
  AST_RST_FLAG_HOLD: assert property ((status[0][`RHP_B_RST_CHG] && !wr_pulse[0] && !pend[0])
    |=> status[0][`RHP_B_RST_CHG])
    else $error("reset done flag lost without a write");

  // writing zero to the reset done flag leaves it set
  AST_ZERO_KEEPS_FLAG: assert property ((wr_pulse[0] && !port_busy_i[0] && !wb_dat_i[`RHP_B_RST_CHG]
    && status[0][`RHP_B_RST_CHG]) |=> status[0][`RHP_B_RST_CHG])
    else $error("zero write cleared reset done flag");

  // a parked write stays parked while the transaction runs
  AST_DEFER_WAIT: assert property ((pend[0] && port_busy_i[0]) |=> pend[0])
    else $error("parked write applied during a transaction");

endmodule

// *** hdl/rhp_cfg.svh ***
// offsets, field positions, reset values and timing counts of the root port registers
`ifndef RHP_CFG_SVH
`define RHP_CFG_SVH
// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define RHP_PORT_COUNT 2
`define RHP_IDX_W 8
`define RHP_RD_IDX_P1 8'h15
`define RHP_RD_IDX_P2 8'h16
`define RHP_WR_IDX_P1 8'h95
`define RHP_WR_IDX_P2 8'h96
`define RHP_REG_RESET 32'h0000_0000
// ----------------------------------------
// status field positions
// ----------------------------------------
`define RHP_B_CONNECTED 0
`define RHP_B_ENABLED 1
`define RHP_B_SUSPENDED 2
`define RHP_B_OVERCUR 3
`define RHP_B_RESET 4
`define RHP_B_POWER 8
`define RHP_B_LOWSPEED 9
// ----------------------------------------
// change field positions (write one to clear)
// ----------------------------------------
`define RHP_B_CONN_CHG 16
`define RHP_B_EN_CHG 17
`define RHP_B_SUSP_CHG 18
`define RHP_B_OC_CHG 19
`define RHP_B_RST_CHG 20
// ----------------------------------------
// timing
// ----------------------------------------
`define RHP_CLK_MHZ 250
`define RHP_PORT_RESET_US 10000
`define RHP_PORT_RESET_CYC (`RHP_PORT_RESET_US * `RHP_CLK_MHZ)
`endif

// *** hdl/rhp_pkg.sv ***
// types shared by the root port register bank
package rhp_pkg;
  typedef logic [31:0] rhp_word_t;
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} rhp_bus_st_t;
endpackage

// *** hdl/rhp_rst_timer.sv ***
// timer that stretches one port reset request over the reset signalling time
`timescale 1ns/1ps
`include "rhp_cfg.svh"
module rhp_rst_timer #(
  parameter int unsigned RESET_CYCLES = `RHP_PORT_RESET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic active_o,
  output logic done_o
);
  logic [31:0] count;
  // ----------------------------------------
  // down counter, done pulses in the cycle the count expires
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      count <= 32'h0000_0000;
      active_o <= 1'b0;
    end
    else if (start_i && !active_o)
    begin
      count <= RESET_CYCLES[31:0];
      active_o <= 1'b1;
    end
    else if (active_o)
    begin
      if (count <= 32'h0000_0001)
      begin
        active_o <= 1'b0;
        done_o <= 1'b1;
      end
      count <= count - 32'h0000_0001;
    end
  end
endmodule

// *** hdl/rhp_port.sv ***
// status and control state of one downstream root port
`timescale 1ns/1ps
`include "rhp_cfg.svh"
module rhp_port #(
  parameter int unsigned RESET_CYCLES = `RHP_PORT_RESET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire rhp_pkg::rhp_word_t wdata_i,
  input wire logic busy_i,
  input wire logic connect_i,
  input wire logic overcur_i,
  input wire logic low_speed_i,
  output rhp_pkg::rhp_word_t status_o,
  output logic pend_o,
  output logic reset_drive_o,
  output logic power_o
);
  rhp_pkg::rhp_word_t held;
  rhp_pkg::rhp_word_t cmd;
  logic apply, conn, en, susp, oc, ls, rst_done, rst_start;
  logic [4:0] chg;
  // a write seen mid-transaction is parked and applied once the port is idle
  assign apply = (wr_i || pend_o) && !busy_i;
  assign cmd = pend_o ? held : wdata_i;
  assign rst_start = apply && cmd[`RHP_B_RESET] && conn;
  // ----------------------------------------
  // deferred write holding
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_o <= 1'b0;
      held <= `RHP_REG_RESET;
    end
    else if (wr_i && busy_i)
    begin
      pend_o <= 1'b1;
      held <= wdata_i;
    end
    else if (apply)
      pend_o <= 1'b0;
  end
  rhp_rst_timer #(.RESET_CYCLES(RESET_CYCLES)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(rst_start),
    .active_o(reset_drive_o),
    .done_o(rst_done)
  );
  // ----------------------------------------
  // port state; hardware events win over software commands
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {conn, en, susp, oc, ls, power_o} <= 6'h00;
    end
    else
    begin
      conn <= connect_i;
      oc <= overcur_i;
      ls <= connect_i && low_speed_i;
      if (apply && cmd[`RHP_B_POWER])
        power_o <= 1'b1;
      else if (apply && cmd[`RHP_B_LOWSPEED])
        power_o <= 1'b0;
      if (!connect_i || overcur_i)
        en <= 1'b0;
      else if (rst_done)
        en <= 1'b1;
      else if (apply && cmd[`RHP_B_CONNECTED])
        en <= 1'b0;
      else if (apply && cmd[`RHP_B_ENABLED] && conn)
        en <= 1'b1;
      if (!en)
        susp <= 1'b0;
      else if (apply && cmd[`RHP_B_OVERCUR])
        susp <= 1'b0;
      else if (apply && cmd[`RHP_B_SUSPENDED])
        susp <= 1'b1;
    end
  end
  // ----------------------------------------
  // change flags: set beats a same-cycle write-one clear
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chg <= 5'h00;
    else
    begin
      chg <= (chg & ~(apply ? cmd[`RHP_B_RST_CHG:`RHP_B_CONN_CHG] : 5'h00))
        | {rst_done,
           oc != overcur_i,
           susp && apply && cmd[`RHP_B_OVERCUR],
           en && (!connect_i || overcur_i),
           conn != connect_i};
    end
  end
  // status low word, change flags high word, reserved bits zero
  assign status_o = {11'h000, chg, 6'h00, ls, power_o, 3'h0, reset_drive_o, oc, susp, en, conn};
endmodule

// *** verif/rhp_top_tb_top.sv ***
// self-checking bench for the root port status register bank
`timescale 1ns/1ps
module rhp_top_tb_top;
  // short reset signalling keeps the run brief; expectations follow it
  localparam int unsigned RST_CYC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] port_connect_i = 2'h0;
  logic [1:0] port_overcurrent_i = 2'h0;
  logic [1:0] port_low_speed_i = 2'h0;
  logic [1:0] port_busy_i = 2'h0;
  logic [1:0] port_reset_drive_o;
  logic [1:0] port_power_o;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic [31:0] seed = 32'hf96b948e;
  logic [31:0] d;
  logic [31:0] exp2;

  rhp_top #(.RESET_CYCLES(RST_CYC)) u_rhp_top (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .port_connect_i(port_connect_i),
    .port_overcurrent_i(port_overcurrent_i),
    .port_low_speed_i(port_low_speed_i),
    .port_busy_i(port_busy_i),
    .port_reset_drive_o(port_reset_drive_o),
    .port_power_o(port_power_o)
  );

  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  // 250 MHz core clock
  always #2 clk_i = ~clk_i;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // wishbone master
  // ----------------------------------------
  // entered just after an edge; request held until ack is sampled, then idle one cycle
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 200)
      check("ack wait", 32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // the expectation is queued before the request so the monitor always finds it
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    name_q.push_back(what);
    exp_q.push_back(exp);
    wb_xfer(1'b0, idx, 32'h0000_0000);
  endtask

  // read data is compared in the ack cycle against the oldest queued note
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check(name_q.pop_front(), wb_dat_o, exp_q.pop_front());
  end

  // watchdog sized well above the roughly 150 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    results();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h15, 32'h0000_0000, "p1 after reset");
    rd(8'h16, 32'h0000_0000, "p2 after reset");
    rd(8'h20, 32'h0000_0000, "unmapped read");
    $display("test reset values done");
    port_connect_i <= 2'b01;
    repeat (3) @(posedge clk_i);
    rd(8'h15, 32'h0001_0001, "p1 connect");
    rd(8'h16, 32'h0000_0000, "p2 untouched");
    wb_xfer(1'b1, 8'h95, 32'h0000_0100);
    rd(8'h15, 32'h0001_0101, "p1 power on");
    check("power out", {30'h0, port_power_o}, 32'h1);
    wb_xfer(1'b1, 8'h95, 32'h0000_0000);
    rd(8'h15, 32'h0001_0101, "p1 zero write");
    wb_xfer(1'b1, 8'h95, 32'h0001_0000);
    rd(8'h15, 32'h0000_0101, "p1 connect chg clear");
    $display("test connect and power done");
    wb_xfer(1'b1, 8'h95, 32'h0000_0010);
    rd(8'h15, 32'h0000_0111, "p1 reset active");
    check("reset drive on", {30'h0, port_reset_drive_o}, 32'h1);
    repeat (RST_CYC + 4) @(posedge clk_i);
    rd(8'h15, 32'h0010_0103, "p1 reset done");
    check("reset drive off", {30'h0, port_reset_drive_o}, 32'h0);
    wb_xfer(1'b1, 8'h95, 32'h0001_0000);
    rd(8'h15, 32'h0010_0103, "p1 reset done kept");
    wb_xfer(1'b1, 8'h95, 32'h0010_0000);
    rd(8'h15, 32'h0000_0103, "p1 reset chg clear");
    $display("test port reset done");
    // suspend, resume, disable, then enable through the read index
    wb_xfer(1'b1, 8'h95, 32'h0000_0004);
    rd(8'h15, 32'h0000_0107, "p1 suspend");
    wb_xfer(1'b1, 8'h95, 32'h0000_0008);
    rd(8'h15, 32'h0004_0103, "p1 resume");
    wb_xfer(1'b1, 8'h95, 32'h0000_0001);
    rd(8'h15, 32'h0004_0101, "p1 disable");
    wb_xfer(1'b1, 8'h15, 32'h0004_0002);
    rd(8'h15, 32'h0000_0103, "p1 enable");
    $display("test suspend and enable done");
    port_low_speed_i <= 2'b01;
    port_overcurrent_i <= 2'b10;
    repeat (3) @(posedge clk_i);
    rd(8'h15, 32'h0000_0303, "p1 low speed");
    exp2 = 32'h0008_0008;
    rd(8'h16, exp2, "p2 overcurrent");
    // random flag clears on port two, reserved bits kept zero
    repeat (4)
    begin
      seed = xorshift(seed);
      d = seed & 32'h001f_0000;
      wb_xfer(1'b1, 8'h96, d);
      if (d[19])
        exp2 = 32'h0000_0008;
      rd(8'h16, exp2, "p2 random clear");
    end
    rd(8'h15, 32'h0000_0303, "p1 after p2 writes");
    wb_xfer(1'b1, 8'h96, 32'h0000_0100);
    check("p2 power on", {30'h0, port_power_o}, 32'h3);
    wb_xfer(1'b1, 8'h96, 32'h0000_0200);
    check("p2 power off", {30'h0, port_power_o}, 32'h1);
    $display("test overcurrent and isolation done");
    // power off while a transaction runs must wait for it to end
    port_busy_i <= 2'b01;
    @(posedge clk_i);
    wb_xfer(1'b1, 8'h95, 32'h0000_0200);
    repeat (4) @(posedge clk_i);
    check("power held", {30'h0, port_power_o}, 32'h1);
    // a second write to the parked port is answered only after the first is applied
    fork
      wb_xfer(1'b1, 8'h95, 32'h0000_0100);
      begin
        repeat (4) @(posedge clk_i);
        check("power still held", {30'h0, port_power_o}, 32'h1);
        port_busy_i <= 2'b00;
        repeat (2) @(posedge clk_i);
        check("power off", {30'h0, port_power_o}, 32'h0);
      end
    join
    check("power on again", {30'h0, port_power_o}, 32'h1);
    $display("test deferred write done");
    check("queue drained", 32'(exp_q.size()), 32'h0);
    results();
  end
endmodule
